/* File: rtl/tlt_defines.vh */
/*
 * Shared constants of the transceiver loopback and timing control block:
 * register indices, bus byte addresses, field positions, reset values and counts.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef TLT_DEFINES_VH
`define TLT_DEFINES_VH

// ==========================================================================
// Register indices and Wishbone byte addresses (byte address = 4 * index)
`define TLT_IDX_CFG1 8'h04
`define TLT_IDX_DIAG 8'h05
`define TLT_IDX_FIFO 8'h06
`define TLT_ADR_W 8
`define TLT_ADR_CFG1 8'h10
`define TLT_ADR_DIAG 8'h14
`define TLT_ADR_FIFO 8'h18

// ==========================================================================
// Configuration one control fields
`define TLT_B_SD_POL 6
`define TLT_B_LT_JA 5
`define TLT_B_LT_PLAIN 4
`define TLT_B_LOS_MUTE 3
`define TLT_B_RX_DIS 2
`define TLT_B_CFG1_RSVD 1
`define TLT_B_VCXO_LD 0

// ==========================================================================
// Diagnostic loopback control fields
`define TLT_B_DIGITAL_LOCAL_LOOPBACK 2
`define TLT_B_RLOOP_S 1
`define TLT_B_RLOOP_P 0

// ==========================================================================
// FIFO control and status fields
`define TLT_B_FLUSH_REQ 0
`define TLT_B_FLUSH_BUSY 1
`define TLT_B_SD_STAT 2
`define TLT_B_LOS_STAT 3

// ==========================================================================
// Reset values and widths
`define TLT_CFG1_RST 8'h00
`define TLT_DIAG_RST 3'h0
`define TLT_DATA_W 4
`define TLT_ZERO_DATA 4'h0
`define TLT_ZERO_WORD 32'h0000_0000

// ==========================================================================
// Counts: flush lands inside the allowed 8 to 10 cycle window
`define TLT_FLUSH_CYC 4'h9
`define TLT_FIFO_DEPTH 4
`define TLT_PTR_W 2
`define TLT_DIV16_HALF 5'h08
`define TLT_DIV32_HALF 5'h10

`endif

/* File: rtl/tlt_tx_fifo.v */
/*
 * Transmit elastic FIFO of the loopback block with its manual flush sequencer.
 * Assumes one clock, an already synchronised active-low reset and a clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tlt_defines.vh"

module tlt_tx_fifo (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire flush_req,
    input wire [`TLT_DATA_W-1:0] wr_data,
    output reg [`TLT_DATA_W-1:0] rd_data_q,
    output reg busy_q
);

    reg [`TLT_DATA_W-1:0] mem [0:`TLT_FIFO_DEPTH-1];
    reg [`TLT_PTR_W-1:0] wp_q;
    reg [3:0] cnt_q;
    reg req_q;
    wire [`TLT_PTR_W-1:0] rp;
    wire flushing;

    // Read the oldest entry: one slot ahead of the write pointer
    assign rp = wp_q + 2'h1;
    assign flushing = flush_req | busy_q;

    // ======================================================================
    // Storage, one writer per entry
    genvar g;
    generate
        for (g = 0; g < `TLT_FIFO_DEPTH; g = g + 1) begin : g_ent
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem[g] <= `TLT_ZERO_DATA;
                end else if (clk_en) begin
                    if (flushing) begin
                        mem[g] <= `TLT_ZERO_DATA;
                    end else if (wp_q == g) begin
                        mem[g] <= wr_data;
                    end
                end
            end
        end
    endgenerate

    // ======================================================================
    // Pointer, flush countdown and read port
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= {`TLT_PTR_W{1'b0}};
            cnt_q <= 4'h0;
            req_q <= 1'b0;
            busy_q <= 1'b0;
            rd_data_q <= `TLT_ZERO_DATA;
        end else if (clk_en) begin
            req_q <= flush_req;
            if (flush_req) begin
                busy_q <= 1'b1;
                cnt_q <= 4'h0;
            end else if (req_q) begin
                cnt_q <= `TLT_FLUSH_CYC - 4'h1;
            end else if (busy_q) begin
                if (cnt_q == 4'h0) begin
                    busy_q <= 1'b0; // RQ16
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
            wp_q <= flushing ? {`TLT_PTR_W{1'b0}} : wp_q + 2'h1;
            rd_data_q <= flushing ? `TLT_ZERO_DATA : mem[rp];
        end
    end

endmodule // tlt_tx_fifo
`default_nettype wire

/* File: rtl/tlt_ctrl.v */
/*
 * Loopback and loop-timing control registers with the datapath steering they select.
 * Assumes a classic Wishbone master on ref_clk; detect pins are asynchronous,
 * all data inputs and the recovered clock tick come from logic on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tlt_defines.vh"

// Function
// RQ1 - The detect polarity bit picks whether the external detect pin counts as asserted low or high.
// RQ2 - The jitter-attenuated loop timing bit routes the recovered clock to the de-jitter PLL reference.
// RQ3 - Plain loop timing replaces the local reference with the recovered clock divided by 16 or 32.
// RQ4 - With the mute bit set, loss of signal forces all four receive outputs to zero.
// RQ5 - The receive disable bit forces the receive bus to zero regardless of data.
// RQ6 - The VCXO lock detector runs only while its enable bit is set.
// RQ7 - Digital local loopback returns the transmit inputs onto the receive outputs.
// RQ8 - During digital local loopback the serial transmit output keeps carrying valid data.
// RQ9 - Serial remote loopback sends the received serial input straight back out on transmit.
// RQ10 - During serial remote loopback the receive outputs keep showing recovered data.
// RQ11 - Digital local and serial remote loopback may be enabled at the same time.
// RQ12 - Parallel remote loopback sends deserialized receive data through the FIFO to transmit.
// RQ13 - Software keeps the other two loopbacks off while parallel remote loopback is on.
// RQ14 - Software flushes the transmit FIFO whenever parallel remote loopback changes.
// RQ15 - Software writes zero to the reserved bit one of the first register.
// RQ16 - The FIFO flush completes within 8 to 10 cycles after the flush bit drops.
// RQ17 - Reset clears every control bit and unused bits read as zero.
module tlt_ctrl (
    input wire ref_clk,
    input wire rst_b,
    input wire clk_en,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`TLT_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire ext_signal_detect_in,
    input wire loss_of_signal_detect,
    input wire [`TLT_DATA_W-1:0] tx_par_data_in,
    input wire [`TLT_DATA_W-1:0] rx_deser_data_in,
    input wire rx_serial_in,
    input wire serializer_bit_in,
    input wire ext_local_ref_in,
    input wire rec_clk_tick,
    input wire div32_sel,
    output reg [`TLT_DATA_W-1:0] rx_parallel_data_out,
    output wire [`TLT_DATA_W-1:0] tx_fifo_data_out,
    output reg tx_serial_out,
    output reg cmu_ref_out,
    output reg dejitter_ref_out,
    output reg vcxo_lock_detect_en,
    output reg signal_detect_out
);

    // ======================================================================
    // Reset release
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_n;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // ======================================================================
    // Pin synchronisers: a change counts once stages two and three agree
    reg [2:0] sd_sync_q;
    reg [2:0] los_sync_q;
    reg sd_pin_q;
    reg los_pin_q;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_sync_q <= 3'h0;
            los_sync_q <= 3'h0;
            sd_pin_q <= 1'b0;
            los_pin_q <= 1'b0;
        end else if (clk_en) begin
            sd_sync_q <= {sd_sync_q[1:0], ext_signal_detect_in};
            los_sync_q <= {los_sync_q[1:0], loss_of_signal_detect};
            if (sd_sync_q[1] == sd_sync_q[2]) begin
                sd_pin_q <= sd_sync_q[2];
            end
            if (los_sync_q[1] == los_sync_q[2]) begin
                los_pin_q <= los_sync_q[2];
            end
        end
    end

    // ======================================================================
    // Control registers
    reg [7:0] cfg1_q;
    reg [2:0] diag_q;
    reg flush_req_q;
    wire flush_busy;
    wire wb_req;
    wire wb_wr;
    wire sel_cfg1;
    wire sel_diag;
    wire sel_fifo;
    wire sd_pol;
    wire lt_ja;
    wire lt_plain;
    wire los_mute;
    wire rx_dis;
    wire digital_local_loopback;
    wire rloop_s;
    wire rloop_p;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    assign sel_cfg1 = (wb_adr_i == `TLT_ADR_CFG1);
    assign sel_diag = (wb_adr_i == `TLT_ADR_DIAG);
    assign sel_fifo = (wb_adr_i == `TLT_ADR_FIFO);

    assign sd_pol = cfg1_q[`TLT_B_SD_POL];
    assign lt_ja = cfg1_q[`TLT_B_LT_JA];
    assign lt_plain = cfg1_q[`TLT_B_LT_PLAIN];
    assign los_mute = cfg1_q[`TLT_B_LOS_MUTE];
    assign rx_dis = cfg1_q[`TLT_B_RX_DIS];
    assign digital_local_loopback = diag_q[`TLT_B_DIGITAL_LOCAL_LOOPBACK];
    assign rloop_s = diag_q[`TLT_B_RLOOP_S];
    assign rloop_p = diag_q[`TLT_B_RLOOP_P];

    // Bit seven of the first register is always written zero and the diagnostic register stops at bit two, so both read zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg1_q <= `TLT_CFG1_RST; // RQ17
            diag_q <= `TLT_DIAG_RST; // RQ17
            flush_req_q <= 1'b0; // RQ17
        end else if (clk_en) begin
            if (wb_wr && sel_cfg1) begin
                cfg1_q <= {1'b0, wb_dat_i[6:0]}; // RQ17
            end
            if (wb_wr && sel_diag) begin
                diag_q <= wb_dat_i[2:0]; // RQ11
            end
            if (wb_wr && sel_fifo) begin
                flush_req_q <= wb_dat_i[`TLT_B_FLUSH_REQ];
            end
        end
    end

    // ======================================================================
    // Wishbone answer: one cycle after the request, every address acked
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = `TLT_ZERO_WORD;
        if (sel_cfg1) begin
            rd_mux[7:0] = cfg1_q;
        end else if (sel_diag) begin
            rd_mux[2:0] = diag_q;
        end else if (sel_fifo) begin
            rd_mux[`TLT_B_FLUSH_REQ] = flush_req_q;
            rd_mux[`TLT_B_FLUSH_BUSY] = flush_busy;
            rd_mux[`TLT_B_SD_STAT] = signal_detect_out;
            rd_mux[`TLT_B_LOS_STAT] = los_pin_q;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `TLT_ZERO_WORD;
        end else if (clk_en) begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // ======================================================================
    // Recovered clock divider for loop timing
    reg [4:0] div_cnt_q;
    reg div_clk_q;
    wire [4:0] div_half;

    assign div_half = div32_sel ? `TLT_DIV32_HALF : `TLT_DIV16_HALF;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= 5'h00;
            div_clk_q <= 1'b0;
        end else if (clk_en && rec_clk_tick) begin
            if (div_cnt_q == div_half - 5'h01) begin
                div_cnt_q <= 5'h00;
                div_clk_q <= ~div_clk_q; // RQ3
            end else begin
                div_cnt_q <= div_cnt_q + 5'h01;
            end
        end
    end

    // ======================================================================
    // Transmit FIFO; parallel remote loopback feeds it from the deserializer
    // Mixed loopback modes are not arbitrated: software keeps parallel remote loopback exclusive
    wire [`TLT_DATA_W-1:0] fifo_in;

    assign fifo_in = rloop_p ? rx_deser_data_in : tx_par_data_in; // RQ12 RQ13

    tlt_tx_fifo u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .flush_req(flush_req_q), // RQ14
        .wr_data(fifo_in),
        .rd_data_q(tx_fifo_data_out),
        .busy_q(flush_busy)
    );

    // ======================================================================
    // Receive output, transmit serial, timing references and status
    reg [`TLT_DATA_W-1:0] rx_sel;

    always @* begin
        rx_sel = rx_deser_data_in; // RQ10 RQ12
        if (digital_local_loopback) begin
            rx_sel = tx_par_data_in; // RQ7
        end
        if (los_mute && los_pin_q) begin
            rx_sel = `TLT_ZERO_DATA; // RQ4
        end
        if (rx_dis) begin
            rx_sel = `TLT_ZERO_DATA; // RQ5
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_parallel_data_out <= `TLT_ZERO_DATA;
            tx_serial_out <= 1'b0;
            cmu_ref_out <= 1'b0;
            dejitter_ref_out <= 1'b0;
            vcxo_lock_detect_en <= 1'b0;
            signal_detect_out <= 1'b0;
        end else if (clk_en) begin
            rx_parallel_data_out <= rx_sel;
            // Serializer keeps running in local loopback
            tx_serial_out <= rloop_s ? rx_serial_in : serializer_bit_in; // RQ8 RQ9
            cmu_ref_out <= lt_plain ? div_clk_q : ext_local_ref_in; // RQ3
            dejitter_ref_out <= lt_ja ? div_clk_q : 1'b0; // RQ2
            vcxo_lock_detect_en <= cfg1_q[`TLT_B_VCXO_LD]; // RQ6
            signal_detect_out <= sd_pol ? sd_pin_q : ~sd_pin_q; // RQ1
        end
    end

endmodule // tlt_ctrl
`default_nettype wire

/* File: sim/tlt_ctrl_chk.sv */
/* Checker for tlt_ctrl: bus answers, read masks, datapath sources.
   Assumes a bind to tlt_ctrl and a clk_en that is mostly high. */
`timescale 1ns/1ps
`default_nettype none
module tlt_ctrl_chk (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [3:0] tx_par_data_in,
    input wire logic [3:0] rx_deser_data_in,
    input wire logic rx_serial_in,
    input wire logic serializer_bit_in,
    input wire logic [3:0] rx_parallel_data_out,
    input wire logic [3:0] tx_fifo_data_out,
    input wire logic tx_serial_out
);
    // =====
    // Edge count since release; internal reset lags two edges
    logic [1:0] age_q;
    logic live;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
    end
    assign live = (age_q == 2'h3) && clk_en;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // =====
    // Properties
    ack_one_cycle_a: assert property ($rose(wb_ack_o) |=> !wb_ack_o)
        else $error("ack too long");
    ack_answer_a: assert property (live && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper bits set");
    cfg_unused_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> !wb_dat_o[7])
        else $error("bit 7 set");
    diag_unused_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h14 |->
        wb_dat_o[7:3] == 5'h00) else $error("diag high bits set");
    reset_quiet_a: assert property (age_q != 2'h3 |->
        rx_parallel_data_out == 4'h0 && tx_fifo_data_out == 4'h0) else $error("not quiet");
    ser_loop_a: assert property (live && rx_serial_in == serializer_bit_in |=>
        tx_serial_out == $past(rx_serial_in)) else $error("serial out wrong");
    rx_source_a: assert property (live |=> rx_parallel_data_out == 4'h0 ||
        rx_parallel_data_out == $past(tx_par_data_in) ||
        rx_parallel_data_out == $past(rx_deser_data_in)) else $error("rx source wrong");
    wr_seen_c: cover property (wb_ack_o && wb_we_i);
    rd_seen_c: cover property (wb_ack_o && !wb_we_i && wb_dat_o[7:0] != 8'h00);
    rx_live_c: cover property (live && rx_parallel_data_out != 4'h0);
endmodule // tlt_ctrl_chk
`default_nettype wire

/* File: sim/tlt_framer_model.sv */
/* Framer and line model: fresh random data every cycle, a tick each second cycle.
   Assumes ref_clk from the bench. */
`timescale 1ns/1ps
`default_nettype none
module tlt_framer_model (
    input wire logic ref_clk,
    output logic [3:0] tx_data,
    output logic [3:0] rx_data,
    output logic rx_bit,
    output logic ser_bit,
    output logic tick,
    output logic loc_ref
);
    integer seed = 17882;
    logic [31:0] r;
    initial {tx_data, rx_data, rx_bit, ser_bit, tick, loc_ref} = 12'h000;
    // Values are redrawn every cycle, so a stale path looks right only when a draw repeats
    always @(posedge ref_clk) begin
        r = $random(seed);
        tx_data <= r[3:0];
        rx_data <= r[7:4];
        rx_bit <= r[8];
        ser_bit <= r[9];
        loc_ref <= r[10];
        tick <= ~tick;
    end
endmodule // tlt_framer_model
`default_nettype wire

/* File: sim/tlt_ctrl_tb_top.sv */
/* Bench top of tlt_ctrl: bus tasks, bench model, scenarios, verdict.
   Assumes tlt_framer_model and tlt_ctrl_chk are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tlt_ctrl_tb_top;
    logic ref_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sd = 1'b0;
    logic los = 1'b0, d32 = 1'b0, los_m = 1'b0, c_rx = 1'b0, c_ff = 1'b0;
    logic ack, txs, tx_clock_multiplier, djr, vld, sdo, rxb, serb, tick, lref, e_ts, e_vc, e_cm, e_cv;
    logic [7:0] adr = 8'h00, cfg = 8'h00, diag = 8'h00, d;
    logic [7:0] lb [6] = '{8'h00, 8'h04, 8'h02, 8'h06, 8'h01, 8'h00};
    logic [3:0] sel = 4'h0, txd, rxd, rxo, ff, e_rx;
    logic [3:0] hist[$];
    logic [31:0] wdat = 32'h00000000, rdo, rdat;
    integer bad_count = 0, total_checks = 0, seed = 17882, cyc_n = 0, age = 0, i, j, k, n, t0;
    always #2.5 ref_clk = ~ref_clk;
    tlt_framer_model u_far (.ref_clk(ref_clk), .tx_data(txd), .rx_data(rxd), .rx_bit(rxb),
        .ser_bit(serb), .tick(tick), .loc_ref(lref));
    tlt_ctrl u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdo), .wb_ack_o(ack), .ext_signal_detect_in(sd), .loss_of_signal_detect(los),
        .tx_par_data_in(txd), .rx_deser_data_in(rxd), .rx_serial_in(rxb),
        .serializer_bit_in(serb), .ext_local_ref_in(lref), .rec_clk_tick(tick),
        .div32_sel(d32), .rx_parallel_data_out(rxo), .tx_fifo_data_out(ff), .tx_serial_out(txs),
        .cmu_ref_out(tx_clock_multiplier), .dejitter_ref_out(djr), .vcxo_lock_detect_en(vld),
        .signal_detect_out(sdo));
    // =====
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] v, input logic [3:0] s);
        integer m;
        @(posedge ref_clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, s, 24'h000000, v};
        m = 0;
        do begin
            @(posedge ref_clk);
            m++;
        end while (ack !== 1'b1 && m < 40);
        chk(ack, 1, "ack");
        rdat = rdo;
        {cyc, stb} <= 2'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 8'h00, 4'hF);
        chk(rdat, e, "read");
    endtask
    task automatic set_los(input logic v);
        c_rx <= 1'b0;
        los <= v;
        repeat (10) @(posedge ref_clk);
        los_m <= v;
        @(posedge ref_clk);
        c_rx <= 1'b1;
    endtask
    task automatic flush;
        wb(8'h18, 1'b1, 8'h01, 4'hF);
        rd(8'h18, {28'h0000000, 1'b0, cfg[6] ~^ sd, 2'h3});
        wb(8'h18, 1'b1, 8'h00, 4'hF);
        t0 = cyc_n;
        k = 0;
        do begin
            wb(8'h18, 1'b0, 8'h00, 4'hF);
            k++;
        end while (rdat[1] !== 1'b0 && k < 10);
        chk(cyc_n - t0 >= 9 && cyc_n - t0 <= 13, 1, "flush time");
    endtask
    task give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // =====
    // Bench model, compared every cycle; writes land at the ack edge
    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n > 20000) begin
            bad_count++;
            give_verdict();
        end
        age = rst_b ? age + 1 : 0;
        if (age >= 4) begin
            if (c_rx) chk(rxo, e_rx, "rx");
            chk(txs, e_ts, "tx serial");
            chk(vld, e_vc, "lock en");
            if (e_cv) chk(tx_clock_multiplier, e_cm, "cmu ref");
            if (!cfg[5] || cfg[4]) chk(djr, cfg[5] ? tx_clock_multiplier : 1'b0, "dejitter");
            if (c_ff && hist.size() > 3) chk(ff, hist[3], "fifo");
        end
        if (ack && cyc && stb && we && sel[0] && adr == 8'h10) cfg = wdat[7:0];
        if (ack && cyc && stb && we && sel[0] && adr == 8'h14) diag = wdat[7:0];
        if (age >= 3) begin
            e_rx = (cfg[2] || (cfg[3] && los_m)) ? 4'h0 : diag[2] ? txd : rxd;
            e_ts = diag[1] ? rxb : serb;
            e_vc = cfg[0];
            e_cm = lref;
            e_cv = !cfg[4];
            hist.push_front(diag[0] ? rxd : txd);
            if (hist.size() > 6) hist.pop_back();
        end
    end
    // =====
    // Scenarios
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (12) @(posedge ref_clk);
        {c_rx, c_ff} <= 2'h3;
        rd(8'h10, 0);
        rd(8'h14, 0);
        rd(8'h1C, 0);
        for (i = 0; i < 8; i++) begin
            n = $random(seed);
            d = n[7:0] & 8'hFD;
            wb(8'h10, 1'b1, d, 4'hF);
            rd(8'h10, {25'h0, d[6:0]});
            wb(8'h10, 1'b1, ~d, 4'hE);
            rd(8'h10, {25'h0, d[6:0]});
        end
        $display("register test done");
        wb(8'h10, 1'b1, 8'h00, 4'hF);
        for (i = 0; i < 6; i++) begin
            c_ff <= lb[i][0] == diag[0];
            wb(8'h14, 1'b1, lb[i], 4'hF);
            rd(8'h14, {24'h0, lb[i]});
            if (!c_ff) flush();
            repeat (20) @(posedge ref_clk);
            c_ff <= 1'b1;
            repeat (20) @(posedge ref_clk);
        end
        $display("loopback test done");
        wb(8'h10, 1'b1, 8'h08, 4'hF);
        set_los(1'b1);
        repeat (20) @(posedge ref_clk);
        wb(8'h10, 1'b1, 8'h00, 4'hF);
        set_los(1'b0);
        for (i = 0; i < 4; i++) begin
            wb(8'h10, 1'b1, {1'b0, i[1], 6'h00}, 4'hF);
            sd <= i[0];
            repeat (10) @(posedge ref_clk);
            chk(sdo, i[1] == i[0], "detect");
        end
        $display("mute and detect test done");
        for (i = 0; i < 2; i++) begin
            d32 <= i[0];
            wb(8'h10, 1'b1, 8'h31, 4'hF);
            repeat (80) @(posedge ref_clk);
            for (j = 0; j < 2; j++) begin
                n = 0;
                k = 0;
                d[0] = tx_clock_multiplier;
                while (tx_clock_multiplier === d[0] && k < 100) begin
                    n = n + tick;
                    @(posedge ref_clk);
                    k++;
                end
            end
            chk(n, i ? 16 : 8, "divider");
        end
        $display("divider test done");
        give_verdict();
    end
endmodule // tlt_ctrl_tb_top
bind tlt_ctrl tlt_ctrl_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_par_data_in(tx_par_data_in),
    .rx_deser_data_in(rx_deser_data_in), .rx_serial_in(rx_serial_in),
    .serializer_bit_in(serializer_bit_in), .rx_parallel_data_out(rx_parallel_data_out),
    .tx_fifo_data_out(tx_fifo_data_out), .tx_serial_out(tx_serial_out));
`default_nettype wire
